// ==== hw/fpk_panel.sv ====
// Front-panel interface: digit scan, annunciator latches, key and switch reads, calibrator.
`timescale 1ns/1ps
// Summary of operation
// - One segment pattern feeds all nine digit positions at once.
// - Scan code decodes to one digit select at a time, stepping in order.
// - Each annunciator has a latch, written by host strobe, held until rewritten.
// - Annunciator drive is low to light, high for dark.
// - Key lines are active low; pressed pulls low.
// - Key read enable drives a low data bit for each pressed key.
// - Rotary switch read through the same read buffer as the keys; closed contact reads low.
// - Host switches the calibrator enable output on and off.
// - All transfers use the eight-bit data bus with decoded address selects.
// - Scan runs from 1.25 MHz I/O clock, the 5 MHz clock divided by four.
module fpk_panel
    import fpk_pkg::*;
#(
    parameter int NDIG = DIGITS,
    parameter int NANN = ANN_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_data,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    input wire logic [KEY_W-1:0] i_key_n,
    input wire logic [SW_W-1:0] i_sw_n,
    output logic [DATA_W-1:0] o_data,
    output logic o_data_oe_n,
    output logic [SEG_W-1:0] o_seg,
    output logic [SCAN_W-1:0] o_scan,
    output logic [NDIG-1:0] o_digit_sel,
    output logic [NANN-1:0] o_ann_n,
    output logic o_cal_en
);
    // ****************************************************************
    // Helper: one-hot decode of a scan code
    // ****************************************************************
    function automatic logic [NDIG-1:0] dig_decode(input logic [SCAN_W-1:0] code);
        logic [NDIG-1:0] v;
        v = '0;
        for (int i = 0; i < NDIG; i++) begin
            if (code == SCAN_W'(i)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction

    // ****************************************************************
    // Address decode of host strobes
    // ****************************************************************
    wire wr_seg = i_wr_stb && (i_addr == ADR_SEG);
    wire wr_ann_lo = i_wr_stb && (i_addr == ADR_ANN_LO);
    wire wr_ann_hi = i_wr_stb && (i_addr == ADR_ANN_HI);
    wire wr_cal = i_wr_stb && (i_addr == ADR_CAL);
    wire rd_key = i_rd_stb && (i_addr == ADR_KEY);
    wire rd_sw = i_rd_stb && (i_addr == ADR_SW);
    wire rd_any = rd_key || rd_sw;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [SEG_W-1:0] seg_reg;
    logic [NANN-1:0] ann_reg;
    logic cal_reg;
    logic [SCAN_W-1:0] scan_reg;
    logic [SCAN_W-1:0] scan_next;
    logic [NDIG-1:0] dsel_reg;
    logic [DATA_W-1:0] dout_reg;
    logic [DATA_W-1:0] dout_next;
    logic oe_n_reg;
    logic io_tick;

    // I/O clock enable, 1.25 MHz derived by dividing down.
    fpk_tick_div #(
        .DIV(IO_TICK_CYC)
    ) u_div (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .o_tick(io_tick)
    );

    // Scan step with wrap after the last digit.
    assign scan_next = (scan_reg == SCAN_W'(NDIG - 1)) ? SCAN_RST
                                                      : scan_reg + SCAN_W'(1);

    // Read data: the open-collector style buffers pass the lines as is, so
    // a pressed key or closed contact shows as a low bit.
    assign dout_next = rd_key ? i_key_n : (rd_sw ? i_sw_n : dout_reg);

    // Host-written latches; each holds its value until rewritten.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            seg_reg <= SEG_RST;
            ann_reg <= ANN_RST[NANN-1:0];
            cal_reg <= 1'b0;
        end else begin
            if (wr_seg) begin
                seg_reg <= i_data;
            end
            if (wr_ann_lo) begin
                ann_reg[7:0] <= i_data;
            end
            if (wr_ann_hi) begin
                ann_reg[NANN-1:8] <= i_data[NANN-9:0];
            end
            if (wr_cal) begin
                cal_reg <= i_data[0];
            end
        end
    end

    // Scan counter and registered digit select, stepped on the I/O tick.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            scan_reg <= SCAN_RST;
            dsel_reg <= '0;
        end else if (io_tick) begin
            scan_reg <= scan_next;
            dsel_reg <= dig_decode(scan_next);
        end
    end

    // Read buffer: driven only for the cycle after a read strobe, so the
    // bus is released promptly and never fights the host.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            dout_reg <= '1;
            oe_n_reg <= 1'b1;
        end else begin
            dout_reg <= dout_next;
            oe_n_reg <= !rd_any;
        end
    end

    // Outputs straight from flip-flops.
    assign o_seg = seg_reg;
    assign o_scan = scan_reg;
    assign o_digit_sel = dsel_reg;
    assign o_ann_n = ann_reg;
    assign o_cal_en = cal_reg;
    assign o_data = dout_reg;
    assign o_data_oe_n = oe_n_reg;

    // ****************************************************************
    // Checking aids: cycles since the last I/O tick
    // ****************************************************************
    // The first tick after reset comes one cycle late because the divider
    // registers its pulse, so the spacing is only judged once a tick has
    // been seen.
    localparam logic [7:0] TICK_GAP_LAST = 8'(IO_TICK_CYC - 1);
    logic [7:0] tick_gap_reg;
    logic tick_seen_reg;

    // Gap counter cleared on every tick; it feeds only the checks below.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tick_gap_reg <= 8'h00;
            tick_seen_reg <= 1'b0;
        end else if (io_tick) begin
            tick_gap_reg <= 8'h00;
            tick_seen_reg <= 1'b1;
        end else begin
            tick_gap_reg <= tick_gap_reg + 8'h01;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_ONEHOT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $countones(o_digit_sel) <= 1)
        else $error("More than one digit selected.");
    AST_WRAP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (io_tick && scan_reg == SCAN_LAST) |=> (scan_reg == SCAN_RST))
        else $error("Scan did not wrap to the first digit.");
    AST_TICK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (io_tick && tick_seen_reg) |-> (tick_gap_reg == TICK_GAP_LAST))
        else $error("I/O tick came early.");
    AST_TICK_LATE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!io_tick && tick_seen_reg) |-> (tick_gap_reg < TICK_GAP_LAST))
        else $error("I/O tick is missing.");
    AST_SELMATCH: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        io_tick |=> (o_digit_sel == dig_decode(o_scan)))
        else $error("Digit select does not follow scan code.");
    AST_ANNHOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !(wr_ann_lo || wr_ann_hi) |=> $stable(o_ann_n))
        else $error("Annunciator latch changed without a write.");
    AST_ANNWR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_ann_lo |=> (o_ann_n[7:0] == $past(i_data)))
        else $error("Annunciator drive does not match written data.");
    AST_KEYRD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_key |=> (!o_data_oe_n && o_data == $past(i_key_n)))
        else $error("Key read does not return key lines.");
    AST_SWRD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_sw |=> (!o_data_oe_n && o_data == $past(i_sw_n)))
        else $error("Switch read does not return contact lines.");
    AST_CAL: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_cal |=> (o_cal_en == $past(i_data[0])))
        else $error("Calibrator enable does not follow host write.");
    AST_SEG: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_seg ##1 !wr_seg [*2] |-> (o_seg == $past(i_data, 2)))
        else $error("Segment pattern not held after write.");

    // Latches and buffers move only when the host addresses them; a hold
    // check catches a decode that lets a strobe leak to the wrong target.
    AST_ANNWR_HI: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_ann_hi |=> (o_ann_n[NANN-1:8] == $past(i_data[NANN-9:0])))
        else $error("Upper annunciator drive does not match written data.");
    AST_SEGHOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !wr_seg |=> $stable(o_seg))
        else $error("Segment pattern changed without a write.");
    AST_CALHOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !wr_cal |=> $stable(o_cal_en))
        else $error("Calibrator enable changed without a write.");
    AST_RDIDLE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !rd_any |=> o_data_oe_n)
        else $error("Read buffer enabled without a read.");
    AST_DATAHOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !rd_any |=> $stable(o_data))
        else $error("Read data changed without a read.");

    // Scan: hold between ticks, step by one, and one digit lit once running.
    AST_SCANHOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !io_tick |=> ($stable(o_scan) && $stable(o_digit_sel)))
        else $error("Scan moved between ticks.");
    AST_SCANSTEP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (io_tick && (o_scan != SCAN_LAST)) |=> (o_scan == $past(o_scan) + SCAN_W'(1)))
        else $error("Scan did not step to the next digit.");
    AST_SELONE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        tick_seen_reg |-> ($countones(o_digit_sel) == 1))
        else $error("Running scan does not select exactly one digit.");
endmodule

// ==== hw/fpk_pkg.sv ====
// Package of constants for the front-panel display and key interface.
package fpk_pkg;
    // ****************************************************************
    // Bus and display geometry
    // ****************************************************************
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int DIGITS = 9;
    localparam int SEG_W = 8;
    localparam int ANN_W = 16;
    localparam int KEY_W = 8;
    localparam int SW_W = 8;
    localparam int SCAN_W = 4;

    // ****************************************************************
    // Decoded device selects on the address lines
    // ****************************************************************
    localparam logic [3:0] ADR_SEG = 4'h0;
    localparam logic [3:0] ADR_ANN_LO = 4'h1;
    localparam logic [3:0] ADR_ANN_HI = 4'h2;
    localparam logic [3:0] ADR_KEY = 4'h3;
    localparam logic [3:0] ADR_SW = 4'h4;
    localparam logic [3:0] ADR_CAL = 4'h5;

    // ****************************************************************
    // Reset values and the last scan code
    // ****************************************************************
    localparam logic [7:0] SEG_RST = 8'h00;
    localparam logic [15:0] ANN_RST = 16'hFFFF;
    localparam logic [3:0] SCAN_RST = 4'h0;
    localparam logic [3:0] SCAN_LAST = 4'h8;

    // ****************************************************************
    // Timing: processor clock and the divided I/O clock
    // ****************************************************************
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int CPU_CLK_HZ = 5_000_000;
    localparam int IO_DIV = 4;
    localparam int IO_CLK_HZ = CPU_CLK_HZ / IO_DIV;
    localparam int IO_TICK_CYC = SYS_CLK_HZ / IO_CLK_HZ;
endpackage

// ==== hw/fpk_tick_div.sv ====
// Divider that makes the one-cycle I/O clock enable for the scan logic.
`timescale 1ns/1ps
module fpk_tick_div
    import fpk_pkg::*;
#(
    parameter int DIV = IO_TICK_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    output logic o_tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] TOP = CW'(DIV - 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic tick_reg;
    wire at_top = (cnt_reg == TOP);

    // Free-running count; the pulse is one system cycle per I/O period.
    assign cnt_next = at_top ? '0 : cnt_reg + CW'(1);

    // Counter and registered tick.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= at_top;
        end
    end

    assign o_tick = tick_reg;
endmodule

// ==== sim/fpk_host_model.sv ====
// Host processor model that makes write and read strobes on the parallel bus.
`timescale 1ns/1ps
module fpk_host_model
    import fpk_pkg::*;
(
    input wire logic i_clk_sys,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_data,
    output logic o_wr_stb,
    output logic o_rd_stb
);
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Idle bus starts with both strobes low.
    initial begin
        o_addr = 4'hF;
        o_data = 8'h00;
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
    end

    // One-cycle write strobe; data is inverted after the sampling edge so stale data never
    // passes for valid data.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        o_addr = a;
        o_data = d;
        o_wr_stb = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_wr_stb = 1'b0;
        o_data = ~d;
    endtask

    // One-cycle read strobe; the caller samples the answer on return.
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk_sys);
        #1;
        o_addr = a;
        o_rd_stb = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_rd_stb = 1'b0;
    endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking testbench for the front-panel display and key interface.
`timescale 1ns/1ps
module testbench;
    import fpk_pkg::*;
    logic i_clk_sys;
    logic i_rst;
    logic [KEY_W-1:0] key_n;
    logic [SW_W-1:0] sw_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [DATA_W-1:0] rdata;
    logic oe_n;
    logic [SEG_W-1:0] seg;
    logic [SCAN_W-1:0] scan;
    logic [DIGITS-1:0] dsel;
    logic [ANN_W-1:0] ann_n;
    logic cal_en;
    int n_errors = 0;
    int checks_done = 0;

    fpk_host_model host_u (.i_clk_sys(i_clk_sys), .o_addr(addr), .o_data(wdata),
        .o_wr_stb(wr_stb), .o_rd_stb(rd_stb));
    fpk_panel dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(addr), .i_data(wdata),
        .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .i_key_n(key_n), .i_sw_n(sw_n),
        .o_data(rdata), .o_data_oe_n(oe_n), .o_seg(seg), .o_scan(scan),
        .o_digit_sel(dsel), .o_ann_n(ann_n), .o_cal_en(cal_en));

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    // Case inequality so that an unknown never passes for a match.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Everything dark and idle straight after reset.
    task automatic t_reset();
        chk(ann_n, 16'hFFFF);
        chk(16'(cal_en), 16'h0000);
        chk(16'(oe_n), 16'h0001);
        chk(16'(dsel), 16'h0000);
        chk(16'(scan), 16'(SCAN_RST));
        chk(16'(seg), 16'(SEG_RST));
        chk(16'(rdata), 16'h00FF);
    endtask

    // Back-to-back latch writes with a write to an unmapped select between them that must change nothing.
    task automatic t_write();
        host_u.wr(ADR_ANN_LO, 8'h5A);
        host_u.wr(ADR_ANN_HI, 8'hC3);
        host_u.wr(4'h7, 8'h00);
        host_u.wr(ADR_SEG, 8'hA5);
        host_u.wr(ADR_CAL, 8'h01);
        @(posedge i_clk_sys);
        #1;
        chk(ann_n, 16'hC35A);
        chk(16'(seg), 16'h00A5);
        chk(16'(cal_en), 16'h0001);
        host_u.wr(ADR_CAL, 8'h00);
        @(posedge i_clk_sys);
        #1;
        chk(16'(cal_en), 16'h0000);
        chk(ann_n, 16'hC35A);
    endtask

    // Key and switch reads return raw low-active lines; an unmapped read gets no enable.
    task automatic t_read();
        key_n = 8'hFE;
        sw_n = 8'h7F;
        host_u.rd(ADR_KEY);
        chk(16'(oe_n), 16'h0000);
        chk(16'(rdata), 16'h00FE);
        host_u.rd(ADR_SW);
        chk(16'(oe_n), 16'h0000);
        chk(16'(rdata), 16'h007F);
        @(posedge i_clk_sys);
        #1;
        chk(16'(oe_n), 16'h0001);
        host_u.rd(ADR_SEG);
        chk(16'(oe_n), 16'h0001);
    endtask

    // Watch twelve scan steps: spacing, order, one-hot select and the wrap after the last.
    task automatic t_scan();
        int n;
        logic [3:0] prev;
        for (int s = 0; s < 12; s++) begin
            prev = scan;
            n = 0;
            while (scan === prev && n < 200) begin
                @(posedge i_clk_sys);
                #1;
                n++;
            end
            if (s > 0) chk(16'(n), 16'(IO_TICK_CYC));
            chk(16'(scan), 16'((prev == SCAN_LAST) ? 4'h0 : prev + 4'h1));
            chk(16'(dsel), 16'(9'h001 << scan));
        end
    endtask

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // The whole run is about 970 cycles, so 150 us only trips on a hang.
    initial begin
        #150000;
        n_errors++;
        end_of_test();
    end

    initial begin
        i_rst = 1'b1;
        key_n = 8'hFF;
        sw_n = 8'hFF;
        repeat (8) @(posedge i_clk_sys);
        #1;
        i_rst = 1'b0;
        t_reset();
        t_write();
        t_read();
        t_scan();
        end_of_test();
    end
endmodule
